/* File: srp_checker.sv */
/* checker for the serial register port timing at its pins.
 assumes binding onto srp_serial_port, one core_clk domain, rst active high. */
`timescale 1ns/1ps
module srp_checker #(
	parameter DATA_W = 10
) (
	input wire core_clk,
	input wire rst,
	input wire frame_strobe_n,
	input wire serial_clk,
	input wire serial_dout,
	input wire serial_dout_oe,
	input wire frame_done,
	input wire summary_fault_flag,
	input wire serial_error_flag,
	input wire [DATA_W-1:0] fault_mask_cfg
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_oe_on_fall: assert property ($fell(frame_strobe_n) |-> ##[1:5] serial_dout_oe)
		else $error("output enable late after strobe fall");
	a_oe_off_idle: assert property (frame_strobe_n [*5] |-> !serial_dout_oe)
		else $error("output driven while strobe high");
	a_done_one_cycle: assert property (frame_done |=> !frame_done)
		else $error("frame done longer than one cycle");
	a_done_strobe_high: assert property (frame_done |-> frame_strobe_n && $past(frame_strobe_n))
		else $error("frame done while strobe low");
	a_mask_on_done: assert property ($changed(fault_mask_cfg) |-> ##[0:2] $past(frame_done))
		else $error("register changed without accepted frame");
	a_dout_hold: assert property (($stable(serial_clk) && !frame_strobe_n) [*8] |-> $stable(serial_dout))
		else $error("data out moved without clock falling edge");
	a_err_at_end: assert property ($rose(serial_error_flag) |-> frame_strobe_n && !frame_done)
		else $error("serial error set outside frame end");
	a_err_in_summary: assert property (serial_error_flag |-> summary_fault_flag)
		else $error("summary flag low with serial error");
	c_done: cover property (frame_done);
	c_err_set: cover property ($rose(serial_error_flag));
	c_err_clr: cover property ($fell(serial_error_flag));
endmodule
bind srp_serial_port srp_checker #(.DATA_W(DATA_W)) i_chk (.core_clk, .rst, .frame_strobe_n,
	.serial_clk, .serial_dout, .serial_dout_oe, .frame_done, .summary_fault_flag,
	.serial_error_flag, .fault_mask_cfg);

/* File: srp_host.sv */
/* host model: serial master driving strobe, clock and data in, reading data out.
 assumes core_clk of 25 ns; one serial clock period is eight core cycles. */
`timescale 1ns/1ps
module srp_host (
	input wire core_clk,
	input wire serial_dout,
	input wire serial_dout_oe,
	output reg frame_strobe_n,
	output reg serial_clk,
	output reg serial_din
);
	reg flip = 1'b0;
	// released line shows a changing pattern
	wire sdo_line = serial_dout_oe ? serial_dout : flip;
	initial begin
		frame_strobe_n = 1'b1;
		serial_clk = 1'b0;
		serial_din = 1'b0;
	end
	always @(posedge core_clk) begin
		flip <= ~flip;
	end
	task xfer(input [15:0] w, input integer nb, output [15:0] rx);
		integer i;
		begin
			rx = 16'h0000;
			@(posedge core_clk);
			frame_strobe_n <= 1'b0;
			repeat (10) @(posedge core_clk);
			for (i = 0; i < nb; i = i + 1) begin
				serial_din <= w[(31 - i) % 16];
				repeat (4) @(posedge core_clk);
				serial_clk <= 1'b1;
				repeat (4) @(posedge core_clk);
				if (i < 16) rx[15 - i] = sdo_line;
				serial_clk <= 1'b0;
			end
			repeat (4) @(posedge core_clk);
			frame_strobe_n <= 1'b1;
			serial_din <= ~serial_din;
		end
	endtask
endmodule

/* File: srp_map.vh */
/*
 serial register port constants: frame layout, register indices, status bit positions,
 reset values. assumes inclusion by srp_serial_port.v only.
*/
`ifndef SRP_MAP_VH
`define SRP_MAP_VH
`define SRP_FRAME_BITS 16
`define SRP_CNT_W 5
`define SRP_ADDR_HI 15
`define SRP_ADDR_LO 12
`define SRP_WR_BIT 11
`define SRP_DATA_HI 10
`define SRP_DATA_LO 1
`define SRP_DATA_W 10
`define SRP_PREFIX_BITS 5
`define SRP_REG_PWM_TIMING 4'h0
`define SRP_REG_PWM_DITHER 4'h1
`define SRP_REG_CURRENT 4'h2
`define SRP_REG_DIAG_CFG 4'h3
`define SRP_REG_UNUSED 4'h4
`define SRP_REG_SINGLE_STEP 4'h5
`define SRP_REG_SYSTEM 4'h6
`define SRP_REG_STEP_LOW 4'h7
`define SRP_REG_STEP_HIGH 4'h8
`define SRP_REG_ACCEL 4'h9
`define SRP_REG_DECEL 4'ha
`define SRP_REG_START_RATE 4'hb
`define SRP_REG_RUN_RATE 4'hc
`define SRP_REG_STEP_READBACK 4'hd
`define SRP_REG_FAULT_MASK 4'he
`define SRP_REG_OVERCURRENT 4'hf
`define SRP_RST_PWM_TIMING 10'h094
`define SRP_RST_CURRENT 10'h270
`define SRP_RST_DIAG_CFG 10'h011
`define SRP_RST_SYSTEM 10'h020
`define SRP_RST_ZERO 10'h000
`define SRP_ST_SUMMARY 15
`define SRP_ST_POR 14
`define SRP_ST_SERIAL_ERR 13
`define SRP_ST_CMD_READY 12
`define SRP_ST_SEQ_ACTIVE 11
`define SRP_ST_OCB 2
`define SRP_ST_OCA 1
`define SRP_MASK_OCB 1
`define SRP_MASK_OCA 0
`define SRP_FAULT_W 8
`define SRP_SYS_SLEEP_BIT 9
`define SRP_SYS_SLEEP_REQ 10
`define SRP_SYS_DSR 4
`endif

/* File: srp_serial_port.v */
/*
 four-wire serial register port of a stepper driver: 16-bit frames, odd parity,
 status prefix on read-back, fault mask, overcurrent detail register.
 assumes the serial clock, data in and strobe are asynchronous pins sampled on core_clk,
 and the serial clock is slow (200 ns) against core_clk (25 ns).
*/
`timescale 1ns/1ps
`include "srp_map.vh"

// Operation
// - strobe low: shift data-in on each serial clock rising edge.
// - strobe high: ignore serial clock, shift nothing.
// - data output released (enable low) whenever strobe is high.
// - after 16 bits, strobe rising edge latches word and acts on it.
// - wrong edge count: drop write, skip clearing, set serial-error flag.
// - serial-error flag cleared by valid write, external reset, sleep cycle, power-on.
// - after external-reset clear, monitor rearms only after one valid transfer.
// - frame msb first: address 15:12, write select 11, data 10:1, parity 0.
// - write select one stores data unless read-only; zero reads addressed register.
// - every frame has odd parity over 16 bits, generated fresh each transfer.
// - received frame with bad parity is not written.
// - output msb first, advancing on each serial clock falling edge.
// - summary fault flag driven as soon as strobe falls.
// - first five output bits are status bits 15:11 always.
// - write select one returns status bits 10:1 in data field.
// - register 15 read-only; write stores nothing, returns status.
// - fault mask covers every status fault bit except summary, power-on, serial-error.
// - masked monitor creates no fault state and sets no flag.
// - step count low register holds direction, run mode, low 8 bits; high holds upper 8.
// - single-step register holds home-reset bit and signed microstep amount.
// - summary flag high whenever any other status fault bit is set.
// - status bit 13 shows previous transfer failed.
module srp_serial_port #(
	parameter DATA_W = 10
) (
	input wire core_clk,
	input wire rst,
	input wire frame_strobe_n,
	input wire serial_clk,
	input wire serial_din,
	output reg serial_dout,
	output wire serial_dout_oe,
	input wire external_reset_n,
	input wire [`SRP_FAULT_W-1:0] monitor_faults,
	input wire [7:0] overcurrent_events,
	input wire command_ready,
	input wire step_sequence_active,
	input wire [DATA_W-1:0] step_readback_value,
	output wire [DATA_W-1:0] pwm_timing_cfg,
	output wire [DATA_W-1:0] pwm_dither_cfg,
	output wire [DATA_W-1:0] current_bridge_cfg,
	output wire [DATA_W-1:0] diagnostics_cfg,
	output wire [DATA_W-1:0] system_cfg,
	output wire step_angle_home_reset,
	output wire [5:0] microstep_move_amount,
	output wire step_direction,
	output wire continuous_run_select,
	output wire [7:0] step_count_low_bits,
	output wire [7:0] step_count_high_bits,
	output wire [DATA_W-1:0] acceleration_cfg,
	output wire [DATA_W-1:0] deceleration_cfg,
	output wire [DATA_W-1:0] start_rate_cfg,
	output wire [DATA_W-1:0] run_rate_cfg,
	output wire [DATA_W-1:0] fault_mask_cfg,
	output reg frame_done,
	output wire summary_fault_flag,
	output wire serial_error_flag
);

	function [DATA_W-1:0] reset_value;
		input [3:0] idx;
		begin
			case (idx)
				`SRP_REG_PWM_TIMING: reset_value = `SRP_RST_PWM_TIMING;
				`SRP_REG_CURRENT: reset_value = `SRP_RST_CURRENT;
				`SRP_REG_DIAG_CFG: reset_value = `SRP_RST_DIAG_CFG;
				`SRP_REG_SYSTEM: reset_value = `SRP_RST_SYSTEM;
				default: reset_value = `SRP_RST_ZERO;
			endcase
		end
	endfunction

	function is_writable;
		input [3:0] idx;
		begin
			is_writable = (idx != `SRP_REG_UNUSED) && (idx != `SRP_REG_STEP_READBACK) &&
				(idx != `SRP_REG_OVERCURRENT);
		end
	endfunction

	// pin synchronisers
	wire [3:0] pin_raw = {serial_din, external_reset_n, serial_clk, frame_strobe_n};
	wire [3:0] pin_s;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			reg meta_r;
			reg sync_r;
			always @(posedge core_clk) begin
				if (rst) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else begin
					meta_r <= pin_raw[g];
					sync_r <= meta_r;
				end
			end
			assign pin_s[g] = sync_r;
		end
	endgenerate

	// edge detection on synchronised pins
	reg sck_prev_r;
	reg strb_prev_r;
	always @(posedge core_clk) begin
		if (rst) begin
			sck_prev_r <= 1'b1;
			strb_prev_r <= 1'b1;
		end else begin
			sck_prev_r <= pin_s[1];
			strb_prev_r <= pin_s[0];
		end
	end
	wire strb_s = pin_s[0];
	wire sck_s = pin_s[1];
	wire ext_rst_n_s = pin_s[2];
	wire din_s = pin_s[3];
	wire strb_fall = strb_prev_r & ~strb_s;
	wire strb_rise = ~strb_prev_r & strb_s;
	wire sck_rise = ~sck_prev_r & sck_s & ~strb_s;
	wire sck_fall = sck_prev_r & ~sck_s & ~strb_s;

	// register file
	reg [DATA_W-1:0] regs_r [0:15];
	reg [`SRP_FRAME_BITS-1:0] rx_r;
	reg [`SRP_FRAME_BITS-1:0] tx_r;
	reg [`SRP_CNT_W-1:0] cnt_r;
	reg overflow_r;
	reg serr_r;
	reg por_r;
	reg monitor_armed_r;
	reg ext_rst_prev_r;
	reg [`SRP_FAULT_W-1:0] fault_r;
	reg [7:0] oc_r;
	reg par_r;

	wire [3:0] rx_addr = rx_r[`SRP_ADDR_HI:`SRP_ADDR_LO];
	wire rx_wr = rx_r[`SRP_WR_BIT];
	wire parity_ok = ^rx_r;
	wire len_ok = (cnt_r == `SRP_FRAME_BITS) && !overflow_r;
	wire frame_ok = strb_rise && len_ok && parity_ok;
	wire sleep_write = frame_ok && rx_wr && (rx_addr == `SRP_REG_SYSTEM) &&
		(rx_r[`SRP_SYS_SLEEP_REQ] || rx_r[`SRP_SYS_SLEEP_BIT]);
	wire ext_pulse = ext_rst_prev_r & ~ext_rst_n_s;
	wire [DATA_W-1:0] fmask = regs_r[`SRP_REG_FAULT_MASK];
	wire dsr = regs_r[`SRP_REG_SYSTEM][`SRP_SYS_DSR];
	wire status_read = frame_ok && !rx_wr && !dsr;

	// status word
	wire oc_b = |oc_r[7:4];
	wire oc_a = |oc_r[3:0];
	reg [`SRP_FRAME_BITS-1:0] status;
	wire any_fault = por_r | serr_r | (|fault_r) | oc_a | oc_b;
	always @* begin
		status = 16'h0000;
		status[`SRP_ST_SUMMARY] = any_fault;
		status[`SRP_ST_POR] = por_r;
		status[`SRP_ST_SERIAL_ERR] = serr_r;
		status[`SRP_ST_CMD_READY] = command_ready;
		status[`SRP_ST_SEQ_ACTIVE] = step_sequence_active;
		status[`SRP_DATA_HI:`SRP_DATA_HI-`SRP_FAULT_W+1] = fault_r;
		status[`SRP_ST_OCB] = oc_b & ~fmask[`SRP_MASK_OCB];
		status[`SRP_ST_OCA] = oc_a & ~fmask[`SRP_MASK_OCA];
	end
	assign summary_fault_flag = any_fault;
	assign serial_error_flag = serr_r;

	// readback data of an address
	function [DATA_W-1:0] regs_data_of;
		input [3:0] a;
		begin
			case (a)
				`SRP_REG_UNUSED: regs_data_of = `SRP_RST_ZERO;
				`SRP_REG_STEP_READBACK: regs_data_of = step_readback_value;
				`SRP_REG_OVERCURRENT: regs_data_of = {2'h0, oc_r};
				default: regs_data_of = regs_r[a];
			endcase
		end
	endfunction

	// masks and frame positions
	wire [`SRP_FAULT_W-1:0] fault_allow = ~fmask[`SRP_DATA_HI-1:`SRP_DATA_LO+1];
	wire [7:0] oc_allow = {{4{~fmask[`SRP_MASK_OCB]}}, {4{~fmask[`SRP_MASK_OCA]}}};
	wire [`SRP_FAULT_W-1:0] fault_masked = monitor_faults & fault_allow;
	wire [7:0] oc_masked = overcurrent_events & oc_allow;
	wire oc_read = frame_ok && !rx_wr && (rx_addr == `SRP_REG_OVERCURRENT) && !dsr;
	wire fault_clear = status_read || ext_pulse || sleep_write;
	wire oc_clear = oc_read || ext_pulse || sleep_write;
	wire last_bit = (cnt_r == `SRP_FRAME_BITS - 1);
	wire prefix_done = (cnt_r == `SRP_PREFIX_BITS - 1);
	wire [DATA_W-1:0] field_data = din_s ? status[`SRP_DATA_HI:`SRP_DATA_LO] :
		regs_data_of(rx_r[`SRP_ADDR_HI-`SRP_ADDR_LO:0]);

	// receive shift register and edge count
	reg [`SRP_FRAME_BITS-1:0] rx_nxt;
	reg [`SRP_CNT_W-1:0] cnt_nxt;
	reg overflow_nxt;
	always @* begin
		rx_nxt = rx_r;
		cnt_nxt = cnt_r;
		overflow_nxt = overflow_r;
		if (strb_fall) begin
			cnt_nxt = 5'h00;
			overflow_nxt = 1'b0;
		end else if (sck_rise) begin
			rx_nxt = {rx_r[`SRP_FRAME_BITS-2:0], din_s};
			if (cnt_r == `SRP_FRAME_BITS)
				overflow_nxt = 1'b1;
			else
				cnt_nxt = cnt_r + 5'h01;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			rx_r <= 16'h0000;
			cnt_r <= 5'h00;
			overflow_r <= 1'b0;
		end else begin
			rx_r <= rx_nxt;
			cnt_r <= cnt_nxt;
			overflow_r <= overflow_nxt;
		end
	end

	// transmit shift register with running parity
	always @(posedge core_clk) begin
		if (rst) begin
			tx_r <= 16'h0000;
			par_r <= 1'b0;
			serial_dout <= 1'b0;
		end else if (strb_fall) begin
			tx_r <= {status[`SRP_FRAME_BITS-1:1], 1'b0};
			par_r <= status[`SRP_ST_SUMMARY];
			serial_dout <= status[`SRP_ST_SUMMARY];
		end else if (sck_rise && prefix_done) begin
			tx_r[`SRP_FRAME_BITS-2:0] <= {field_data, 5'h00};
		end else if (sck_fall) begin
			if (last_bit) begin
				serial_dout <= ~par_r;
			end else begin
				serial_dout <= tx_r[`SRP_FRAME_BITS-2];
				par_r <= par_r ^ tx_r[`SRP_FRAME_BITS-2];
			end
			tx_r <= {tx_r[`SRP_FRAME_BITS-2:0], 1'b0};
		end
	end

	// register file
	integer i;
	always @(posedge core_clk) begin
		if (rst) begin
			for (i = 0; i < 16; i = i + 1) begin
				regs_r[i] <= reset_value(i[3:0]);
			end
			frame_done <= 1'b0;
		end else begin
			frame_done <= frame_ok;
			if (frame_ok && rx_wr && is_writable(rx_addr))
				regs_r[rx_addr] <= rx_r[`SRP_DATA_HI:`SRP_DATA_LO];
		end
	end

	// serial error flag: a set wins over a clear
	always @(posedge core_clk) begin
		if (rst) begin
			serr_r <= 1'b0;
			monitor_armed_r <= 1'b1;
			ext_rst_prev_r <= 1'b1;
		end else begin
			ext_rst_prev_r <= ext_rst_n_s;
			if (frame_ok || ext_pulse || sleep_write)
				serr_r <= 1'b0;
			if (strb_rise && !frame_ok && monitor_armed_r)
				serr_r <= 1'b1;
			if (frame_ok)
				monitor_armed_r <= 1'b1;
			else if (ext_pulse)
				monitor_armed_r <= 1'b0;
		end
	end

	// fault latches: present events survive a clear
	always @(posedge core_clk) begin
		if (rst) begin
			por_r <= 1'b1;
			fault_r <= 8'h00;
			oc_r <= 8'h00;
		end else begin
			if (fault_clear) begin
				por_r <= 1'b0;
				fault_r <= fault_masked;
			end else begin
				fault_r <= fault_r | fault_masked;
			end
			if (oc_clear)
				oc_r <= oc_masked;
			else
				oc_r <= oc_r | oc_masked;
		end
	end

	assign serial_dout_oe = ~strb_s & ~strb_fall;
	assign pwm_timing_cfg = regs_r[`SRP_REG_PWM_TIMING];
	assign pwm_dither_cfg = regs_r[`SRP_REG_PWM_DITHER];
	assign current_bridge_cfg = regs_r[`SRP_REG_CURRENT];
	assign diagnostics_cfg = regs_r[`SRP_REG_DIAG_CFG];
	assign system_cfg = regs_r[`SRP_REG_SYSTEM];
	assign step_angle_home_reset = regs_r[`SRP_REG_SINGLE_STEP][9];
	assign microstep_move_amount = regs_r[`SRP_REG_SINGLE_STEP][5:0];
	assign step_direction = regs_r[`SRP_REG_STEP_LOW][9];
	assign continuous_run_select = regs_r[`SRP_REG_STEP_LOW][8];
	assign step_count_low_bits = regs_r[`SRP_REG_STEP_LOW][7:0];
	assign step_count_high_bits = regs_r[`SRP_REG_STEP_HIGH][7:0];
	assign acceleration_cfg = regs_r[`SRP_REG_ACCEL];
	assign deceleration_cfg = regs_r[`SRP_REG_DECEL];
	assign start_rate_cfg = regs_r[`SRP_REG_START_RATE];
	assign run_rate_cfg = regs_r[`SRP_REG_RUN_RATE];
	assign fault_mask_cfg = fmask;
endmodule

/* File: tb.sv */
/* testbench for the serial register port: host model frames, queued expectations.
 assumes srp_host, srp_checker and the design are compiled first. */
`timescale 1ns/1ps
module tb;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg external_reset_n = 1'b1;
	reg [7:0] monitor_faults = 8'h00;
	reg [7:0] overcurrent_events = 8'h00;
	reg command_ready = 1'b0;
	reg step_sequence_active = 1'b0;
	reg [9:0] step_readback_value = 10'h000;
	wire frame_strobe_n, serial_clk, serial_din, serial_dout, serial_dout_oe, frame_done;
	wire summary_fault_flag, serial_error_flag, step_angle_home_reset, step_direction;
	wire continuous_run_select;
	wire [5:0] microstep_move_amount;
	wire [7:0] step_count_low_bits, step_count_high_bits;
	wire [9:0] fault_mask_cfg;
	integer n_errors = 0, n_checks = 0, seed = 46, i;
	reg [31:0] rnd;
	reg [15:0] rx;
	reg [9:0] d;
	reg [15:0] exp_q[$], seen_q[$];
	string name_q[$];
	initial forever #12.5 core_clk = ~core_clk;
	srp_host i_host (.core_clk, .serial_dout, .serial_dout_oe, .frame_strobe_n, .serial_clk,
		.serial_din);
	srp_serial_port i_dut (.core_clk, .rst, .frame_strobe_n, .serial_clk, .serial_din, .serial_dout,
		.serial_dout_oe, .external_reset_n, .monitor_faults, .overcurrent_events, .command_ready,
		.step_sequence_active, .step_readback_value, .pwm_timing_cfg(), .pwm_dither_cfg(),
		.current_bridge_cfg(), .diagnostics_cfg(), .system_cfg(), .step_angle_home_reset,
		.microstep_move_amount, .step_direction, .continuous_run_select, .step_count_low_bits,
		.step_count_high_bits, .acceleration_cfg(), .deceleration_cfg(), .start_rate_cfg(),
		.run_rate_cfg(), .fault_mask_cfg, .frame_done, .summary_fault_flag, .serial_error_flag);
	function [15:0] mk(input [3:0] a, input wr, input [9:0] dv);
		mk = {a, wr, dv, ~^{a, wr, dv}};
	endfunction
	task check(input string nm, input [15:0] seen, input [15:0] e);
		begin
			name_q.push_back(nm);
			seen_q.push_back(seen);
			exp_q.push_back(e);
		end
	endtask
	task cmp(input string nm, input [15:0] seen, input [15:0] e);
		begin
			n_checks = n_checks + 1;
			if (seen !== e) begin
				n_errors = n_errors + 1;
				$display("MISMATCH %s expected %h seen %h", nm, e, seen);
			end
		end
	endtask
	// compares every noted expectation, oldest first, against what was seen
	always @(posedge core_clk) begin
		while (exp_q.size() > 0) begin
			cmp(name_q[0], seen_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(seen_q.pop_front());
			void'(name_q.pop_front());
		end
	end
	task roll;
		begin
			rnd = $random(seed);
			d = rnd[9:0];
		end
	endtask
	task frame(input [15:0] w, input integer nb);
		begin
			i_host.xfer(w, nb, rx);
			repeat (8) @(posedge core_clk);
			if (nb == 16) check("rx parity", 16'(^rx), 16'h0001);
		end
	endtask
	task test_done;
		begin
			repeat (2) @(posedge core_clk);
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors = n_errors + 1;
		test_done;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		roll;
		rst <= 1'b0;
		{command_ready, step_sequence_active, step_readback_value} <= rnd[11:0];
		repeat (4) @(posedge core_clk);
		roll;
		frame(mk(4'he, 1'b1, d), 16);
		check("prefix", 16'(rx[15:11]), {11'h0, 3'b110, command_ready, step_sequence_active});
		check("status low", 16'(rx[10:1]), 16'h0000);
		check("mask cfg", 16'(fault_mask_cfg), 16'(d));
		frame(mk(4'he, 1'b0, 10'h000), 16);
		check("mask read", 16'(rx[10:1]), 16'(d));
		frame(mk(4'he, 1'b1, ~d) ^ 16'h0001, 16);
		check("mask kept", 16'(fault_mask_cfg), 16'(d));
		roll;
		frame(mk(4'h7, 1'b1, d), 16);
		check("err prefix", 16'(rx[13]), 16'h0001);
		check("err cleared", 16'(serial_error_flag), 16'h0000);
		check("step low", 16'({step_direction, continuous_run_select, step_count_low_bits}), 16'(d));
		for (i = 15; i < 18; i = i + 2) begin
			frame(mk(4'h8, 1'b1, 10'h0ff), i);
			check("count err", 16'(serial_error_flag), 16'h0001);
			check("high kept", 16'(step_count_high_bits), 16'h0000);
		end
		frame(mk(4'h8, 1'b1, d), 16);
		check("step high", 16'(step_count_high_bits), 16'(d[7:0]));
		roll;
		frame(mk(4'h5, 1'b1, d), 16);
		check("single step", 16'({step_angle_home_reset, microstep_move_amount}), 16'({d[9], d[5:0]}));
		frame(mk(4'he, 1'b1, 10'h3ff), 16);
		overcurrent_events <= 8'h10;
		frame(mk(4'hf, 1'b1, 10'h0aa), 16);
		check("ro write", 16'(rx[10:1]), 16'h0000);
		frame(mk(4'hf, 1'b0, 10'h000), 16);
		check("masked detail", 16'(rx[10:1]), 16'h0000);
		frame(mk(4'he, 1'b1, 10'h000), 16);
		frame(mk(4'hf, 1'b0, 10'h000), 16);
		check("oc detail", 16'(rx[10:1]), 16'h0010);
		check("summary", 16'(summary_fault_flag), 16'h0001);
		overcurrent_events <= 8'h00;
		frame(mk(4'h4, 1'b1, 10'h3ff), 16);
		frame(mk(4'h4, 1'b0, 10'h000), 16);
		check("unused read", 16'(rx[10:1]), 16'h0000);
		frame(mk(4'hd, 1'b0, 10'h000), 16);
		check("readback", 16'(rx[10:1]), 16'(step_readback_value));
		frame(mk(4'h0, 1'b1, 10'h000), 15);
		external_reset_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		external_reset_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		check("ext reset", 16'(serial_error_flag), 16'h0000);
		frame(mk(4'h0, 1'b1, 10'h000), 15);
		check("disarmed", 16'(serial_error_flag), 16'h0000);
		frame(mk(4'h9, 1'b1, 10'h015), 16);
		frame(mk(4'h0, 1'b1, 10'h000), 15);
		check("rearmed", 16'(serial_error_flag), 16'h0001);
		test_done;
	end
endmodule
